/* File: hw/cig_pkg.sv */
// Constants, register map and carrier types of the configuration block
package cig_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_BANK_SEL    = 8'ha9;
  localparam logic [7:0] IDX_SLEEP_CTRL  = 8'hac;
  localparam logic [7:0] IDX_IRQ_PIN     = 8'had;
  localparam logic [7:0] IDX_GAIN_SEARCH = 8'haf;
  localparam logic [7:0] IDX_GAIN_MAX    = 8'hcf;
  localparam logic [7:0] IDX_IRQ_STATUS  = 8'he0;
  localparam logic [7:0] IDX_IRQ_MASK    = 8'he1;
  localparam logic [7:0] IDX_DEV_STATE   = 8'he2;
  localparam logic [7:0] IDX_TT_FIRST    = 8'hb0;
  localparam logic [7:0] IDX_TT_LAST     = 8'hbf;
  localparam logic [7:0] IDX_MIRROR_END  = 8'h7f;

  // Field positions
  localparam int BANK_LSB      = 0;
  localparam int SAI_BIT       = 4;
  localparam int PIN_SRC_LSB   = 4;
  localparam int INVERT_BIT    = 3;
  localparam int MAX_START_BIT = 6;

  // Reset values, gain code limits and table depth
  localparam logic [1:0] BANK_RST      = 2'h0;
  localparam logic [3:0] SLEEP_RSVD_LO = 4'hc;
  localparam logic [7:0] GAIN_MAX_RST  = 8'h99;
  localparam logic [3:0] GAIN_CODE_TOP = 4'hb;
  localparam logic [3:0] GAIN_CODE_MIN = 4'h0;
  localparam int         TT_DEPTH      = 16;

  // Interrupt pin source codes
  localparam logic [2:0] SRC_NORMAL = 3'h0;
  localparam logic [2:0] SRC_RSVD   = 3'h1;
  localparam logic [2:0] SRC_ALS    = 3'h2;
  localparam logic [2:0] SRC_AUX0   = 3'h3;
  localparam logic [2:0] SRC_AUX1   = 3'h4;

  // Status and mask bit positions
  localparam int ST_ALS   = 0;
  localparam int ST_AUX0  = 1;
  localparam int ST_AUX1  = 2;
  localparam int ST_AGC   = 3;
  localparam int ST_SLEEP = 4;
  localparam int ST_W     = 5;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } cig_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } cig_wb_rsp_t;

  typedef struct packed {
    logic als;
    logic aux0;
    logic aux1;
  } cig_evt_t;

  typedef enum logic [0:0] {
    AGC_IDLE,
    AGC_SEARCH
  } cig_agc_st_t;

  typedef struct packed {
    cig_agc_st_t st;
    logic [3:0]  gain;
    logic        done;
  } cig_agc_t;

  typedef struct packed {
    logic                      ack;
    logic [31:0]               rdat;
    logic [1:0]                bank;
    logic                      sleep_after_irq;
    logic [2:0]                pin_src;
    logic                      invert;
    logic                      max_start;
    logic [7:0]                gain_max;
    logic [ST_W-1:0]           status;
    logic [ST_W-1:0]           mask;
    logic                      irq;
    logic                      pin;
    logic                      osc_run;
    logic [TT_DEPTH-1:0][7:0]  ttab;
  } cig_state_t;

endpackage : cig_pkg

/* File: hw/cig_gain_search.sv */
// ALS gain search: steps gain down from a start value until no saturation
`timescale 1ns/10ps
module cig_gain_search (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic       step_i,
  input  wire logic       sat_i,
  input  wire logic       max_start_i,
  input  wire logic [3:0] gain_max_i,
  output logic      [3:0] gain_o,
  output logic            busy_o,
  output logic            done_o
);
  import cig_pkg::*;

  cig_agc_t   s_ff;
  cig_agc_t   nxt_s;
  logic [3:0] top_gain;

  // Codes above the top are clamped rather than trusted
  assign top_gain = (gain_max_i > GAIN_CODE_TOP) ? GAIN_CODE_TOP : gain_max_i;

  always_comb begin
    nxt_s      = s_ff;
    nxt_s.done = 1'b0;
    case (s_ff.st)
      AGC_IDLE: begin
        if (start_i) begin
          if (max_start_i) begin
            nxt_s.gain = top_gain;
          end
          nxt_s.st = AGC_SEARCH;
        end
      end
      AGC_SEARCH: begin
        if (step_i) begin
          if (sat_i && (s_ff.gain != GAIN_CODE_MIN)) begin
            nxt_s.gain = s_ff.gain - 4'h1;
          end else begin
            nxt_s.st   = AGC_IDLE;
            nxt_s.done = 1'b1;
          end
        end
      end
      default: nxt_s.st = AGC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff <= '{st: AGC_IDLE, gain: GAIN_MAX_RST[3:0], done: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign gain_o = s_ff.gain;
  assign busy_o = (s_ff.st == AGC_SEARCH);
  assign done_o = s_ff.done;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  start_max_a: assert property (
    (!busy_o && start_i && max_start_i) |=> (gain_o == $past(top_gain)))
    else $error("search did not start at maximum gain");
  step_down_a: assert property (
    (busy_o && step_i && sat_i && gain_o != 4'h0)
      |=> (busy_o && gain_o == $past(gain_o) - 4'h1))
    else $error("gain did not step down by one");
  search_end_a: assert property (
    (busy_o && step_i && (!sat_i || gain_o == 4'h0)) |=> (!busy_o && done_o))
    else $error("search did not end");
  gain_range_a: assert property (
    gain_o <= 4'hb)
    else $error("gain code above range");
  floor_reach_c: cover property (busy_o && step_i && sat_i && gain_o == 4'h0);

endmodule : cig_gain_search

/* File: hw/cig_top.sv */
// Configuration bank: memory bank, sleep, interrupt pin, gain search start
//
// Overview of operation
// - Bank 2 or 3 exposes 16 table words at 0xB0-0xBF, mirrored over 0x00-0x7F.
// - Sleep-after-interrupt set: oscillator stops while the interrupt routed to the pin is active.
// - Stopping for sleep-after-interrupt sets the sleep-pending flag.
// - Pin source: 0 normal, 1 reserved, 2 ALS, 3 aux 0, 4 aux 1.
// - Pin is active low; invert bit makes it active high.
// - Max-gain-start makes each ALS gain search begin at configured max gain.
// - Search steps gain down until no saturation or gain code 0.
// - ALS max gain is four bits, codes 0 to 11, reset 9.
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/10ps
module cig_top (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire cig_pkg::cig_wb_req_t wb_req_i,
  output cig_pkg::cig_wb_rsp_t      wb_rsp_o,
  input  wire cig_pkg::cig_evt_t    evt_i,
  input  wire logic                 agc_start_i,
  input  wire logic                 agc_step_i,
  input  wire logic                 agc_sat_i,
  output logic [3:0]                als_gain_o,
  output logic                      agc_busy_o,
  output logic                      irq_o,
  output logic                      irq_pin_o,
  output logic                      osc_run_o
);
  import cig_pkg::*;

  cig_state_t      s_ff;
  cig_state_t      nxt_s;
  logic            req;
  logic            wr;
  logic [7:0]      idx;
  logic [7:0]      wbyte;
  logic            tt_hit;
  logic [3:0]      tt_sel;
  logic [7:0]      tt_rd_val;
  logic [ST_W-1:0] ev_set;
  logic [ST_W-1:0] pend;
  logic            normal_act;
  logic            pin_act;
  logic            agc_done;
  logic            agc_busy;
  logic [3:0]      agc_gain;

  // Only bits 9:2 of the address take part; bits 1:0 are ignored
  assign req   = wb_req_i.cyc && wb_req_i.stb && !s_ff.ack;
  assign wr    = req && wb_req_i.we && wb_req_i.sel[0];
  assign idx   = wb_req_i.adr[9:2];
  assign wbyte = wb_req_i.dat[7:0];

  assign tt_hit = s_ff.bank[1] &&
                  ((idx <= IDX_MIRROR_END) ||
                   (idx >= IDX_TT_FIRST && idx <= IDX_TT_LAST));
  assign tt_sel    = idx[3:0];
  assign tt_rd_val = s_ff.ttab[tt_sel];

  assign pend       = s_ff.status & s_ff.mask;
  assign normal_act = |pend[ST_AGC:ST_ALS];

  always_comb begin
    case (s_ff.pin_src)
      SRC_NORMAL: pin_act = normal_act;
      SRC_ALS:    pin_act = pend[ST_ALS];
      SRC_AUX0:   pin_act = pend[ST_AUX0];
      SRC_AUX1:   pin_act = pend[ST_AUX1];
      default:    pin_act = 1'b0;
    endcase
  end

  always_comb begin
    ev_set           = '0;
    ev_set[ST_ALS]   = evt_i.als;
    ev_set[ST_AUX0]  = evt_i.aux0;
    ev_set[ST_AUX1]  = evt_i.aux1;
    ev_set[ST_AGC]   = agc_done;
    ev_set[ST_SLEEP] = s_ff.sleep_after_irq && pin_act;
  end

  cig_gain_search u_gain_search (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .start_i     (agc_start_i),
    .step_i      (agc_step_i),
    .sat_i       (agc_sat_i),
    .max_start_i (s_ff.max_start),
    .gain_max_i  (s_ff.gain_max[3:0]),
    .gain_o      (agc_gain),
    .busy_o      (agc_busy),
    .done_o      (agc_done)
  );

  always_comb begin
    nxt_s     = s_ff;
    nxt_s.ack = req;

    if (req) begin
      nxt_s.rdat = 32'h0000_0000;
      if (tt_hit) begin
        nxt_s.rdat[7:0] = tt_rd_val;
      end else begin
        case (idx)
          IDX_BANK_SEL:    nxt_s.rdat[1:0] = s_ff.bank;
          IDX_SLEEP_CTRL:  nxt_s.rdat[7:0] = {3'h0, s_ff.sleep_after_irq, SLEEP_RSVD_LO};
          IDX_IRQ_PIN:     nxt_s.rdat[7:0] = {1'b0, s_ff.pin_src,
                                              s_ff.invert, 3'h0};
          IDX_GAIN_SEARCH: nxt_s.rdat[7:0] = {1'b0, s_ff.max_start, 6'h00};
          IDX_GAIN_MAX:    nxt_s.rdat[7:0] = s_ff.gain_max;
          IDX_IRQ_STATUS:  nxt_s.rdat[ST_W-1:0] = s_ff.status;
          IDX_IRQ_MASK:    nxt_s.rdat[ST_W-1:0] = s_ff.mask;
          IDX_DEV_STATE:   nxt_s.rdat[5:0] = {s_ff.osc_run, agc_busy,
                                              agc_gain};
          default:         nxt_s.rdat = 32'h0000_0000;
        endcase
      end
    end

    // Events win over a write-one-to-clear in the same cycle
    nxt_s.status = s_ff.status | ev_set;

    if (wr) begin
      if (tt_hit) begin
        for (int i = 0; i < TT_DEPTH; i++) begin
          if (tt_sel == 4'(i)) begin
            nxt_s.ttab[i] = wbyte;
          end
        end
      end else begin
        case (idx)
          IDX_BANK_SEL:    nxt_s.bank = wbyte[BANK_LSB +: 2];
          IDX_SLEEP_CTRL:  nxt_s.sleep_after_irq = wbyte[SAI_BIT];
          IDX_IRQ_PIN: begin
            nxt_s.pin_src = wbyte[PIN_SRC_LSB +: 3];
            nxt_s.invert  = wbyte[INVERT_BIT];
          end
          IDX_GAIN_SEARCH: nxt_s.max_start = wbyte[MAX_START_BIT];
          // full field stored, clamped where used
          IDX_GAIN_MAX:    nxt_s.gain_max = wbyte;
          IDX_IRQ_STATUS:
            nxt_s.status = (s_ff.status & ~wbyte[ST_W-1:0]) | ev_set;
          IDX_IRQ_MASK:    nxt_s.mask = wbyte[ST_W-1:0];
          default:         nxt_s.bank = s_ff.bank;
        endcase
      end
    end

    nxt_s.irq = |pend;
    nxt_s.pin = s_ff.invert ? pin_act : !pin_act;
    // restart after flag and sources clear, or once sleep-after-interrupt is cleared
    nxt_s.osc_run = !(s_ff.sleep_after_irq && (pin_act || s_ff.status[ST_SLEEP]));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff           <= '0;
      s_ff.bank      <= BANK_RST;
      s_ff.gain_max  <= GAIN_MAX_RST;
      s_ff.pin       <= 1'b1;
      s_ff.osc_run   <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign wb_rsp_o.ack = s_ff.ack;
  assign wb_rsp_o.dat = s_ff.rdat;
  assign als_gain_o   = agc_gain;
  assign agc_busy_o   = agc_busy;
  assign irq_o        = s_ff.irq;
  assign irq_pin_o    = s_ff.pin;
  assign osc_run_o    = s_ff.osc_run;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  tt_mirror_a: assert property (
    (req && !wb_req_i.we && tt_hit)
      |=> (wb_rsp_o.ack && wb_rsp_o.dat[7:0] == $past(tt_rd_val)))
    else $error("table word not returned through alias");
  osc_stop_a: assert property (
    (s_ff.sleep_after_irq && pin_act) |=> !osc_run_o)
    else $error("oscillator still running while interrupt active");
  sleep_flag_a: assert property (
    (s_ff.sleep_after_irq && pin_act) |=> s_ff.status[ST_SLEEP])
    else $error("sleep pending flag not set");
  osc_restart_a: assert property (
    (!s_ff.sleep_after_irq || (!pin_act && !s_ff.status[ST_SLEEP])) |=> osc_run_o)
    else $error("oscillator did not restart");
  pin_route_a: assert property (
    (s_ff.pin_src == SRC_ALS && !s_ff.invert)
      |=> (irq_pin_o == !$past(pend[ST_ALS])))
    else $error("ALS source not routed to pin");
  pin_invert_a: assert property (
    1'b1 |=> (irq_pin_o == ($past(pin_act) ^ !$past(s_ff.invert))))
    else $error("pin polarity wrong");
  rsvd_code_a: assert property (
    (s_ff.pin_src == SRC_RSVD || s_ff.pin_src > SRC_AUX1)
      |=> (irq_pin_o == !$past(s_ff.invert)))
    else $error("reserved source code drove pin active");
  ack_once_a: assert property (
    wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack held longer than one cycle");

  sleep_c: cover property (s_ff.sleep_after_irq && pin_act ##1 !osc_run_o);
  mirror_c: cover property (req && tt_hit && idx <= IDX_MIRROR_END);
  invert_c: cover property (s_ff.invert && pin_act ##1 irq_pin_o);

endmodule : cig_top

/* File: verif/cig_host.sv */
// Host model: classic single-cycle register bus master
`timescale 1ns/10ps
module cig_host (
  input  wire logic                 clk_i,
  output cig_pkg::cig_wb_req_t      wb_req_o,
  input  wire cig_pkg::cig_wb_rsp_t wb_rsp_i
);
  import cig_pkg::*;
  initial wb_req_o = '0;
  // Request held until ack is seen at a rising edge; only the bench
  // watchdog ends a wait that never gets its answer
  task automatic acc(input logic we, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    wb_req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'h0},
                  sel: 4'hf, dat: {24'h0, wd}};
    do begin
      @(posedge clk_i);
    end while (wb_rsp_i.ack !== 1'b1);
    rd = wb_rsp_i.dat;
    wb_req_o <= '0;
  endtask : acc
endmodule : cig_host

/* File: verif/config_irq_pin_agc_start_test.sv */
// Self-checking bench of the configuration bank
`timescale 1ns/10ps
module config_irq_pin_agc_start_test;
  import cig_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  cig_wb_req_t wb_req;
  cig_wb_rsp_t wb_rsp;
  cig_evt_t    evt   = '0;
  logic        start = 1'b0;
  logic        step  = 1'b0;
  logic        sat   = 1'b0;
  logic [3:0]  gain;
  logic        busy;
  logic        irq;
  logic        pin;
  logic        osc;
  logic [31:0] rd;
  logic [7:0]  tab [16];
  logic [3:0]  m;
  int          fail_count = 0;
  int          checked    = 0;
  int          seed       = 25396;

  always #4 clk_i = ~clk_i;

  cig_host i_host (.clk_i(clk_i), .wb_req_o(wb_req), .wb_rsp_i(wb_rsp));
  cig_top i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
    .evt_i(evt), .agc_start_i(start), .agc_step_i(step),
    .agc_sat_i(sat), .als_gain_o(gain), .agc_busy_o(busy),
    .irq_o(irq), .irq_pin_o(pin), .osc_run_o(osc));

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    i_host.acc(1'b1, idx, d, rd);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    i_host.acc(1'b0, idx, 8'h0, rd);
    chk(rd, {24'h0, exp});
  endtask : rdc

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  task automatic pulse(input cig_evt_t e);
    @(posedge clk_i);
    evt <= e;
    @(posedge clk_i);
    evt <= '0;
    cyc(5);
  endtask : pulse

  // One start or step request, then a settled cycle
  task automatic agc(input logic st, input logic s);
    @(posedge clk_i);
    start <= st;
    step  <= ~st;
    sat   <= s;
    @(posedge clk_i);
    start <= 1'b0;
    step  <= 1'b0;
    cyc(1);
  endtask : agc

  function automatic logic pin_exp(input logic [2:0] s, input int e,
                                   input logic inv);
    logic act;
    act = (s == SRC_NORMAL) || (s == SRC_ALS && e == 0) ||
          (s == SRC_AUX0 && e == 1) || (s == SRC_AUX1 && e == 2);
    return inv ? act : ~act;
  endfunction : pin_exp

  initial begin
    cyc(6);
    rst_i <= 1'b0;
    cyc(1);
    chk(pin, 1'b1);
    rdc(IDX_SLEEP_CTRL, 8'h0c);
    rdc(IDX_IRQ_PIN, 8'h00);
    rdc(IDX_GAIN_SEARCH, 8'h00);
    rdc(IDX_GAIN_MAX, 8'h99);
    rdc(8'h10, 8'h00);
    wr(IDX_BANK_SEL, {7'h1, 1'($random(seed))});
    for (int k = 0; k < 16; k++) begin
      tab[k] = 8'($random(seed));
      wr(IDX_TT_FIRST + 8'(k), tab[k]);
    end
    for (int k = 0; k < 16; k++) begin
      rdc({1'b0, 3'($random(seed)), 4'(k)}, tab[k]);
    end
    wr(IDX_BANK_SEL, 8'h00);
    wr(IDX_IRQ_MASK, 8'h1f);
    for (int s = 0; s < 8; s++) begin
      for (int i = 0; i < 2; i++) begin
        for (int e = 0; e < 3; e++) begin
          wr(IDX_IRQ_STATUS, 8'h1f);
          wr(IDX_IRQ_PIN, {1'b0, 3'(s), 1'(i), 3'h0});
          pulse(3'(4 >> e));
          chk(pin, pin_exp(3'(s), e, 1'(i)));
          chk(irq, 1'b1);
        end
      end
    end
    wr(IDX_IRQ_STATUS, 8'h1f);
    wr(IDX_IRQ_PIN, 8'h20);
    wr(IDX_SLEEP_CTRL, 8'h10);
    rdc(IDX_SLEEP_CTRL, 8'h1c);
    pulse(3'h4);
    chk(osc, 1'b0);
    rdc(IDX_IRQ_STATUS, 8'h11);
    wr(IDX_IRQ_STATUS, 8'h01);
    cyc(3);
    chk(osc, 1'b0);
    wr(IDX_IRQ_STATUS, 8'h10);
    cyc(3);
    chk(osc, 1'b1);
    wr(IDX_SLEEP_CTRL, 8'h00);
    wr(IDX_IRQ_MASK, 8'h00);
    pulse(3'h2);
    chk(irq, 1'b0);
    // search from max gain down to 0.5x
    // Unsigned first: a negative draw would give a code outside 0 to 11
    m = 4'($unsigned($random(seed)) % 32'd12);
    wr(IDX_GAIN_MAX, {4'h9, m});
    wr(IDX_GAIN_SEARCH, 8'h40);
    wr(IDX_IRQ_STATUS, 8'h1f);
    wr(IDX_IRQ_MASK, 8'h08);
    agc(1'b1, 1'b0);
    chk(gain, m);
    chk(busy, 1'b1);
    for (int i = 0; i < int'(m); i++) begin
      agc(1'b0, 1'b1);
      chk(gain, m - 4'(i + 1));
    end
    agc(1'b0, 1'b1);
    chk(busy, 1'b0);
    chk(gain, 4'h0);
    cyc(3);
    chk(irq, 1'b1);
    wr(IDX_GAIN_SEARCH, 8'h00);
    agc(1'b1, 1'b0);
    chk(gain, 4'h0);
    agc(1'b0, 1'b0);
    chk(busy, 1'b0);
    complete_run();
  end

  initial begin
    #200000;
    fail_count++;
    complete_run();
  end
endmodule : config_irq_pin_agc_start_test
